// file: verif/led_fault_monitor.sv
// checker for the led fault status logic
`timescale 1ns/10ps
module led_fault_monitor
	import led_fault_pkg::*;
#(parameter int NCH = 16) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [2*NCH-1:0] output_state_regs,
	input wire logic thermal_flag_det,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic [NCH-1:0] chan_enable,
	input wire logic thermal_flag,
	input wire logic fault_summary
);
	logic [NCH-1:0] on_w;
	logic fl_w;
	for (genvar i = 0; i < NCH; i++) begin : g_on
		assign on_w[i] = |output_state_regs[2*i+:2];
	end
	assign fl_w = reg_addr inside {[OFS_FAULT_CH0:OFS_FAULT_CH12]};
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ====
	// assertions
	hot_rise_a: assert property ($rose(thermal_flag_det) |-> ##[2:4] thermal_flag) else $error("flag late");
	hot_fall_a: assert property ($fell(thermal_flag_det) |-> ##[2:4] !thermal_flag) else $error("no recovery");
	hot_off_a: assert property (thermal_flag |-> chan_enable == '0) else $error("outputs on");
	restore_a: assert property (!thermal_flag && !$past(thermal_flag) |-> chan_enable == $past(on_w))
		else $error("bad enable");
	unmapped_a: assert property (reg_rd && !fl_w && reg_addr != OFS_SECOND_MODE_REG |=> reg_rdata == 8'h00)
		else $error("unmapped read");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
	mode_read_a: assert property (reg_rd && reg_addr == OFS_SECOND_MODE_REG |=>
		reg_rdata[7:6] == {$past(thermal_flag), $past(fault_summary)}) else $error("mode bits");
	no_dne_a: assert property (reg_rd && fl_w |=> (reg_rdata & (reg_rdata >> 1) & 8'h55) == 8'h00)
		else $error("code 11");
	cover property (thermal_flag);
	cover property (fault_summary);
	cover property (reg_rd && fl_w);
endmodule
bind led_fault_status led_fault_monitor #(.NCH(NCH)) i_mon (.mclk, .arst_n, .output_state_regs, .thermal_flag_det,
	.reg_rd, .reg_addr, .reg_rdata, .chan_enable, .thermal_flag, .fault_summary);

// file: verif/led_load_model.sv
// led strings, their comparators and the die sensor
`timescale 1ns/10ps
module led_load_model (
	input wire logic [15:0] chan_enable,
	input wire logic [15:0] open_fault,
	input wire logic [15:0] short_fault,
	input wire logic hot,
	output logic [15:0] open_cmp,
	output logic [15:0] short_cmp,
	output logic thermal_flag_det
);
	// an off channel carries no current, so it looks open too
	assign open_cmp = open_fault | ~chan_enable;
	assign short_cmp = short_fault;
	assign thermal_flag_det = hot;
endmodule

// file: verif/test_led_fault_status.sv
// self-checking bench for the led fault status logic
`timescale 1ns/10ps
module test_led_fault_status;
	import led_fault_pkg::*;
	logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, hot = 0, ot, tflag, fsum;
	logic [31:0] st = '0;
	logic [127:0] duty = '0, gain = '0;
	logic [15:0] opf = '0, shf = '0, en, ocmp, scmp;
	logic [7:0] addr = '0, wdat = '0, rdat;
	int n_errors = 0, total_checks = 0;
	always #50 mclk = ~mclk;
	led_load_model i_load (.chan_enable(en), .open_fault(opf), .short_fault(shf), .hot(hot),
		.open_cmp(ocmp), .short_cmp(scmp), .thermal_flag_det(ot));
	led_fault_status i_dut (.mclk(mclk), .arst_n(arst_n), .output_state_regs(st), .channel_duty_reg(duty),
		.current_gain(gain), .open_cmp(ocmp), .short_cmp(scmp), .thermal_flag_det(ot), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdat), .reg_rdata(rdat), .chan_enable(en),
		.thermal_flag(tflag), .fault_summary(fsum));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk);
		reg_rd = 1;
		addr = a;
		@(negedge mclk);
		reg_rd = 0;
		chk("rdata", {8'h00, exp}, {8'h00, rdat});
	endtask
	task automatic clr;
		@(negedge mclk);
		reg_wr = 1;
		addr = OFS_SECOND_MODE_REG;
		wdat = 8'h10;
		@(negedge mclk);
		reg_wr = 0;
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (400) @(posedge mclk);
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (5) @(negedge mclk);
		arst_n = 1;
		for (int a = 'h45; a < 'h4b; a++) rd(8'(a), 8'h00);
		rd(OFS_SECOND_MODE_REG, 8'h00);
		// full-on ch0 at duty 0, dimmed ch5 tested, ch10 at 255 and ch11 below 8 skipped
		st = 32'h00e0_0801;
		duty = 128'h0000_0000_07ff_0000_0000_6400_0000_0000;
		gain = 128'h0000_0000_2020_0000_0000_2000_0000_0020;
		shf = 16'h8401;
		opf = 16'h0820;
		repeat (5) @(negedge mclk);
		rd(OFS_FAULT_CH0, 8'h01);
		rd(OFS_FAULT_CH4, 8'h08);
		rd(OFS_FAULT_CH8, 8'h00);
		rd(OFS_FAULT_CH12, 8'h00);
		rd(OFS_SECOND_MODE_REG, 8'h40);
		clr();
		rd(OFS_FAULT_CH0, 8'h01);
		hot = 1;
		repeat (5) @(negedge mclk);
		chk("enable", 16'h0000, en);
		rd(OFS_SECOND_MODE_REG, 8'hc0);
		hot = 0;
		repeat (5) @(negedge mclk);
		chk("enable", 16'h0c21, en);
		rd(OFS_SECOND_MODE_REG, 8'h40);
		// faulty channels switched off: codes stay until cleared
		st = 32'h00e0_0000;
		repeat (5) @(negedge mclk);
		rd(OFS_FAULT_CH4, 8'h08);
		clr();
		rd(OFS_FAULT_CH0, 8'h00);
		rd(OFS_FAULT_CH4, 8'h00);
		rd(OFS_SECOND_MODE_REG, 8'h00);
		end_of_test();
	end
endmodule

// file: verilog/led_fault_pkg.sv
// constants for the led fault status logic
package led_fault_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] OFS_SECOND_MODE_REG      = 8'h01;
	localparam logic [7:0] OFS_FAULT_CH0  = 8'h46;
	localparam logic [7:0] OFS_FAULT_CH4  = 8'h47;
	localparam logic [7:0] OFS_FAULT_CH8  = 8'h48;
	localparam logic [7:0] OFS_FAULT_CH12 = 8'h49;
	// ==========================================
	// field positions in the second mode register
	localparam int BIT_THERMAL_FLAG = 7;
	localparam int BIT_FAULT_SUM    = 6;
	localparam int BIT_FAULT_CLEAR  = 4;
	// ==========================================
	// fault codes and output state codes
	localparam logic [1:0] CODE_NO_ERROR = 2'h0;
	localparam logic [1:0] CODE_SHORT    = 2'h1;
	localparam logic [1:0] CODE_OPEN     = 2'h2;
	localparam logic [1:0] STATE_OFF     = 2'h0;
	localparam logic [1:0] STATE_FULL_ON = 2'h1;
	localparam logic [1:0] STATE_DIM     = 2'h2;
	localparam logic [1:0] STATE_DIM_GRP = 2'h3;
	// ==========================================
	// duty limits, reset values and channel count
	localparam logic [7:0] DUTY_MIN_CHECK = 8'h08;
	localparam logic [7:0] DUTY_FULL      = 8'hFF;
	localparam logic [7:0] RST_SECOND_MODE_REG_LOW  = 8'h00;
	localparam logic [7:0] RST_FLAGS      = 8'h00;
	localparam int         NUM_CHAN       = 16;
endpackage

// file: verilog/led_fault_status.sv
// fault codes, summary, clear and thermal shutdown for a sixteen-channel led driver
// Operation
// [RULE1] two-bit code per channel, four per byte
// [RULE2] code 01 means short-circuit detected
// [RULE3] code 10 open, 00 none, 11 never
// [RULE4] host zeroes state and gain of unused channels
// [RULE5] test channels fully on or dimmed
// [RULE6] summary fault bit 6 of mode register
// [RULE7] codes clear once fault gone and clear written
// [RULE8] dimmed: skip checks if duty below 8 or 255
// [RULE9] open when current below half target
// [RULE10] open checked only on enabled channel
// [RULE11] short when output voltage above threshold
// [RULE12] short checked only on enabled channel
// [RULE13] host switches off faulty channels
// [RULE14] overtemperature disables all outputs until cooled
// [RULE15] thermal flag bit 7 while overtemperature
// [RULE16] recovery restores outputs, clears flag automatically
// [RULE17] state code 01 is fully on
// [RULE18] comparator inputs pass two flip-flops
`timescale 1ns/10ps
module led_fault_status
	import led_fault_pkg::*;
#(
	parameter int NCH = led_fault_pkg::NUM_CHAN
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic [2*NCH-1:0] output_state_regs,
	input  wire logic [8*NCH-1:0] channel_duty_reg,
	input  wire logic [8*NCH-1:0] current_gain,
	input  wire logic [NCH-1:0]   open_cmp,
	input  wire logic [NCH-1:0]   short_cmp,
	input  wire logic             thermal_flag_det,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	output logic      [NCH-1:0]   chan_enable,
	output logic                  thermal_flag,
	output logic                  fault_summary
);
	import led_fault_pkg::*;

	// ==========================================
	// input synchronisers
	logic [2*NCH:0] raw_in;
	logic [2*NCH:0] syn_in;
	logic [NCH-1:0] open_s;
	logic [NCH-1:0] short_s;
	logic           hot_s;

	assign raw_in = {thermal_flag_det, short_cmp, open_cmp};

	sync2 #(
		.WIDTH(2*NCH+1)
	) u_sync (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.async_in (raw_in),
		.sync_out (syn_in)
	); // [RULE18]

	assign open_s  = syn_in[NCH-1:0];
	assign short_s = syn_in[2*NCH-1:NCH];
	assign hot_s   = syn_in[2*NCH];

	// ==========================================
	// clear bit write strobe
	logic clear_wr;
	assign clear_wr = reg_wr && (reg_addr == OFS_SECOND_MODE_REG) && reg_wdata[BIT_FAULT_CLEAR]; // [RULE7]

	// ==========================================
	// per-channel qualification and fault codes
	logic [2*NCH-1:0] code_q;
	logic [NCH-1:0]   tested;
	logic [NCH-1:0]   lit;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_chan
			logic [1:0] st;
			logic [7:0] duty;
			logic [7:0] gain;
			logic       dimmed;
			logic       duty_ok;
			logic       det_open;
			logic       det_short;

			assign st      = output_state_regs[2*g +: 2];
			assign duty    = channel_duty_reg[8*g +: 8];
			assign gain    = current_gain[8*g +: 8];
			assign dimmed  = (st == STATE_DIM) || (st == STATE_DIM_GRP);
			// full duty or very short pulses give the comparators no settled window
			assign duty_ok = (duty >= DUTY_MIN_CHECK) && (duty != DUTY_FULL); // [RULE8]
			// zeroed state and gain exclude a channel; the host does this for unused ones
			assign lit     = 1'b0;
			assign tested[g] = !hot_s && (gain != 8'h00)
				&& ((st == STATE_FULL_ON) || (dimmed && duty_ok)); // [RULE5] [RULE4] [RULE17]
			assign det_open  = tested[g] && open_s[g]; // [RULE9] [RULE10]
			// a short wins when both comparators fire, so code 11 cannot arise
			assign det_short = tested[g] && short_s[g]; // [RULE11] [RULE12]

			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					code_q[2*g +: 2] <= CODE_NO_ERROR;
				end else if (det_short) begin
					code_q[2*g +: 2] <= CODE_SHORT; // [RULE2]
				end else if (det_open) begin
					code_q[2*g +: 2] <= CODE_OPEN; // [RULE3]
				end else if (clear_wr) begin
					// a live fault on the same edge wins over the clear
					code_q[2*g +: 2] <= CODE_NO_ERROR; // [RULE7]
				end
			end
		end
	endgenerate

	// ==========================================
	// summary fault bit
	logic fault_any;
	always_comb begin
		fault_any = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			fault_any = fault_any | (|code_q[2*i +: 2]);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fault_summary <= 1'b0;
		end else begin
			fault_summary <= fault_any; // [RULE6]
		end
	end

	// ==========================================
	// thermal shutdown; hysteresis lives in the detector, which releases below the lower limit
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			thermal_flag <= 1'b0;
		end else begin
			thermal_flag <= hot_s; // [RULE15] [RULE16]
		end
	end

	// outputs are gated, not rewritten, so the prior state returns by itself
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			chan_enable <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				chan_enable[i] <= !hot_s && (output_state_regs[2*i +: 2] != STATE_OFF); // [RULE14] [RULE16]
			end
		end
	end

	// ==========================================
	// register read port
	logic [7:0] rdata_d;
	always_comb begin
		rdata_d = RST_FLAGS;
		if (reg_addr == OFS_FAULT_CH0) begin
			rdata_d = code_q[7:0]; // [RULE1]
		end else if (reg_addr == OFS_FAULT_CH4) begin
			rdata_d = code_q[15:8];
		end else if (reg_addr == OFS_FAULT_CH8) begin
			rdata_d = code_q[23:16];
		end else if (reg_addr == OFS_FAULT_CH12) begin
			rdata_d = code_q[31:24];
		end else if (reg_addr == OFS_SECOND_MODE_REG) begin
			rdata_d = RST_SECOND_MODE_REG_LOW;
			rdata_d[BIT_THERMAL_FLAG] = thermal_flag;
			rdata_d[BIT_FAULT_SUM]    = fault_summary;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= RST_FLAGS;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end
endmodule

// file: verilog/sync2.sv
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/10ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
